// ### rtl/rds_data_readout_port.sv
// Serial readout port of the broadcast data decoder, with APB registers.
// Assumes demodulated bits arrive on pclk as one-cycle strobes; pins are async.
//
// Our own choices: the address map and the APB register port.
`timescale 1ns/100ps
module rds_data_readout_port #(
  parameter int BUF_DEPTH = rds_pkg::BUF_DEPTH
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [7:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic test_pin,
  input wire logic mode_pin,
  input wire logic reset_pin,
  input wire logic demod_valid,
  input wire logic demod_bit,
  input wire logic demod_reliable,
  input wire logic valid_data_detect,
  input wire logic readout_clock_i,
  output logic readout_clock_o,
  output logic readout_clock_oe,
  output logic serial_data_out,
  output logic shared_status_o,
  output logic shared_status_oe
);

  localparam int READY_BOUND = rds_pkg::READY_UPDATE_CYCLES;

  typedef struct packed {
    rds_pkg::readout_mode_t mode;
    rds_pkg::master_state_t mstate;
    logic detected;
    logic clk;
    logic clk_oe;
    logic clk_prev;
    logic data;
    logic rel;
    logic ready;
    logic ss_oe;
    logic [15:0] cnt;
    logic [15:0] ctrl;
    logic [15:0] bits;
    logic [31:0] prdata;
    logic slverr;
  } port_t;

  port_t st;
  port_t n;

  logic [3:0] pins_s;
  logic test_s;
  logic mode_s;
  logic rst_s;
  logic clk_s;
  logic clk_fall;
  logic store_push;
  logic store_pop;
  logic store_head;
  logic store_empty;
  logic store_full;
  logic [rds_pkg::BUF_AW:0] store_fill;

  function automatic logic addr_mapped(input logic [7:0] a);
    addr_mapped = (a == rds_pkg::ADDR_CTRL) || (a == rds_pkg::ADDR_STATUS)
      || (a == rds_pkg::ADDR_BITS);
  endfunction : addr_mapped

  pin_sync #(
    .W(4)
  ) u_pin_sync (
    .pclk(pclk),
    .presetn(presetn),
    .d({readout_clock_i, reset_pin, mode_pin, test_pin}),
    .q(pins_s)
  );

  assign test_s = pins_s[0];
  assign mode_s = pins_s[1];
  assign rst_s = pins_s[2];
  assign clk_s = pins_s[3];

  // Buffer depth left open, overflow drops the newest bit
  bit_store #(
    .DEPTH(BUF_DEPTH),
    .AW(rds_pkg::BUF_AW)
  ) u_bit_store (
    .pclk(pclk),
    .presetn(presetn),
    .clear(rst_s),
    .push(store_push),
    .push_bit(demod_bit),
    .pop(store_pop),
    .head(store_head),
    .empty(store_empty),
    .full(store_full),
    .fill(store_fill)
  );

  always_comb
  begin
    n = st;
    n.clk_prev = clk_s;
    clk_fall = st.clk_prev && !clk_s;
    store_push = 1'b0;
    store_pop = 1'b0;
    // Forbidden test combination falls back to standby
    if (test_s)
      n.mode = rds_pkg::MODE_STANDBY;
    else if (mode_s)
      n.mode = rds_pkg::MODE_SLAVE;
    else
      n.mode = rds_pkg::MODE_MASTER;
    if (rst_s)
    begin
      n.detected = 1'b0;
      n.rel = 1'b0;
      n.ready = 1'b0;
    end
    else if (valid_data_detect)
      n.detected = 1'b1;
    n.clk_oe = (n.mode == rds_pkg::MODE_MASTER);
    n.ss_oe = 1'b0;
    case (n.mode)
      rds_pkg::MODE_MASTER:
      begin
        if (!n.detected)
        begin
          n.clk = 1'b1;
          n.data = 1'b1;
          n.mstate = rds_pkg::M_IDLE;
        end
        else
        begin
          case (st.mstate)
            rds_pkg::M_IDLE:
            begin
              // Bits landing mid-pulse are lost; bit spacing makes that moot
              if (demod_valid && !rst_s)
              begin
                n.data = demod_bit;
                n.rel = demod_reliable;
                n.clk = 1'b1;
                n.cnt = st.ctrl;
                n.mstate = rds_pkg::M_HIGH;
                n.bits = st.bits + 16'h0001;
              end
            end
            rds_pkg::M_HIGH:
            begin
              // Data holds through the fall so the host can sample there
              if (st.cnt <= 16'h0001)
              begin
                n.clk = 1'b0;
                n.mstate = rds_pkg::M_IDLE;
              end
              else
                n.cnt = st.cnt - 16'h0001;
            end
            default:
              n.mstate = rds_pkg::M_IDLE;
          endcase
        end
        n.ss_oe = !n.rel;
      end
      rds_pkg::MODE_SLAVE:
      begin
        n.mstate = rds_pkg::M_IDLE;
        n.clk = 1'b0;
        // Only bits that arrive once detection is set and reset pin is low land here
        store_push = demod_valid && n.detected && !rst_s;
        store_pop = clk_fall && !rst_s;
        if (store_pop && !store_empty)
          n.bits = st.bits + 16'h0001;
        n.data = store_head;
        n.ready = !store_empty && !rst_s;
        n.ss_oe = !n.ready;
      end
      default:
      begin
        n.mstate = rds_pkg::M_IDLE;
      end
    endcase
    if (psel && !penable)
    begin
      n.slverr = !addr_mapped(paddr);
      case (paddr)
        rds_pkg::ADDR_CTRL:
          n.prdata = {16'h0000, st.ctrl};
        rds_pkg::ADDR_STATUS:
        begin
          n.prdata = 32'h0000_0000;
          n.prdata[rds_pkg::ST_MASTER] = (st.mode == rds_pkg::MODE_MASTER);
          n.prdata[rds_pkg::ST_SLAVE] = (st.mode == rds_pkg::MODE_SLAVE);
          n.prdata[rds_pkg::ST_STANDBY] = (st.mode == rds_pkg::MODE_STANDBY);
          n.prdata[rds_pkg::ST_DETECTED] = st.detected;
          n.prdata[rds_pkg::ST_READY] = st.ready;
          n.prdata[rds_pkg::ST_FILL_LSB +: rds_pkg::BUF_AW + 1] = store_fill;
        end
        rds_pkg::ADDR_BITS:
          n.prdata = {16'h0000, st.bits};
        default:
          n.prdata = 32'h0000_0000;
      endcase
    end
    // Clamp keeps the clock high time legal whatever software writes
    if (psel && penable && pwrite && paddr == rds_pkg::ADDR_CTRL)
      n.ctrl = (pwdata[15:0] < rds_pkg::CLK_HIGH_MIN) ? rds_pkg::CLK_HIGH_MIN : pwdata[15:0];
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      st <= '0;
      st.mode <= rds_pkg::MODE_STANDBY;
      st.clk <= 1'b1;
      st.data <= 1'b1;
      st.ctrl <= rds_pkg::CTRL_RESET;
    end
    else
      st <= n;
  end

  assign prdata = st.prdata;
  assign pready = 1'b1;
  assign pslverr = st.slverr;
  assign readout_clock_o = st.clk;
  assign readout_clock_oe = st.clk_oe;
  assign serial_data_out = st.data;
  assign shared_status_o = 1'b0;
  assign shared_status_oe = st.ss_oe;

  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  chk_master_drive: assert property (
    st.mode == rds_pkg::MODE_MASTER |-> readout_clock_oe && (shared_status_oe == !st.rel))
    else $error("master mode without clock drive or flag");

  chk_slave_input: assert property (
    st.mode == rds_pkg::MODE_SLAVE |-> !readout_clock_oe && (shared_status_oe == !st.ready))
    else $error("slave mode drives clock or wrong ready");

  chk_standby_release: assert property (
    st.mode == rds_pkg::MODE_STANDBY |-> !readout_clock_oe && !shared_status_oe)
    else $error("standby still drives pins");

  chk_reset_clears: assert property (
    rst_s |=> !st.ready && !st.detected && store_empty)
    else $error("reset did not clear ready, detection or buffer");

  chk_flag_follows: assert property (
    $rose(readout_clock_o) && st.detected && $past(st.mode) == rds_pkg::MODE_MASTER
    && st.mode == rds_pkg::MODE_MASTER |-> shared_status_oe == !$past(demod_reliable))
    else $error("reliability flag does not match the bit");

  chk_open_drain: assert property (
    !shared_status_o)
    else $error("status pin driven high");

  chk_pre_detect_high: assert property (
    st.mode == rds_pkg::MODE_MASTER && !st.detected |-> readout_clock_o && serial_data_out)
    else $error("master outputs not high before detection");

  chk_ready_update: assert property (
    st.mode == rds_pkg::MODE_SLAVE && clk_fall |->
    ##[1:READY_BOUND] (st.ready == !store_empty || st.mode != rds_pkg::MODE_SLAVE))
    else $error("ready not updated in time after clock fall");

  chk_slave_hold: assert property (
    st.mode == rds_pkg::MODE_SLAVE && $past(st.mode) == rds_pkg::MODE_SLAVE
    && clk_s && $past(clk_s) |-> $stable(serial_data_out))
    else $error("slave data moved while clock high");

  chk_ready_drop: assert property (
    store_pop && store_fill == 1 && !store_push && !rst_s |->
    ##2 (!st.ready || st.mode != rds_pkg::MODE_SLAVE))
    else $error("ready stayed high after last bit");

  chk_no_early_store: assert property (
    !st.detected && !valid_data_detect |-> !store_push)
    else $error("bit stored before first detection");

  cov_master_bit: cover property (
    st.mode == rds_pkg::MODE_MASTER && $fell(readout_clock_o) && st.detected);

  cov_slave_pop: cover property (st.mode == rds_pkg::MODE_SLAVE && store_pop && !store_empty);

  cov_switch_to_slave: cover property (
    $past(st.mode) == rds_pkg::MODE_MASTER && st.mode == rds_pkg::MODE_SLAVE);

  cov_ready_fall: cover property (st.mode == rds_pkg::MODE_SLAVE && $fell(st.ready));

endmodule : rds_data_readout_port

// ### rtl/rds_pkg.sv
// Constants, register map and types shared by the readout port files.
// Assumes a single 125 MHz pclk domain; all pins are synchronised elsewhere.
package rds_pkg;

  // Clock and timing
  localparam int CLK_PERIOD_NS = 8;
  localparam int READY_UPDATE_DELAY_NS = 750;
  localparam int READY_UPDATE_CYCLES = READY_UPDATE_DELAY_NS / CLK_PERIOD_NS;
  localparam int CLK_HIGH_MIN_NS = 750;
  localparam int CLK_HIGH_CYCLES = (CLK_HIGH_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // Slave buffer, depth must be a power of two
  localparam int BUF_DEPTH = 64;
  localparam int BUF_AW = 6;

  // Register offsets
  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_STATUS = 8'h04;
  localparam logic [7:0] ADDR_BITS = 8'h08;

  // Control reset value and write minimum
  localparam logic [15:0] CTRL_RESET = 16'(CLK_HIGH_CYCLES);
  localparam logic [15:0] CLK_HIGH_MIN = 16'(CLK_HIGH_CYCLES);

  // Status field positions
  localparam int ST_MASTER = 0;
  localparam int ST_SLAVE = 1;
  localparam int ST_STANDBY = 2;
  localparam int ST_DETECTED = 3;
  localparam int ST_READY = 4;
  localparam int ST_FILL_LSB = 8;

  typedef enum logic [1:0] {MODE_MASTER, MODE_SLAVE, MODE_STANDBY} readout_mode_t;
  typedef enum logic {M_IDLE, M_HIGH} master_state_t;

endpackage : rds_pkg

// ### rtl/pin_sync.sv
// Two-flop synchroniser for a group of unrelated pin levels.
// Assumes each bit is a slow level; no bus coherency across bits.
`timescale 1ns/100ps
module pin_sync #(
  parameter int W = 4
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);

  typedef struct packed {
    logic [W-1:0] meta;
    logic [W-1:0] sync;
  } sync_t;

  sync_t r;
  sync_t n;

  always_comb
  begin
    n = r;
    n.meta = d;
    n.sync = r.meta;
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      r <= '0;
    else
      r <= n;
  end

  assign q = r.sync;

endmodule : pin_sync

// ### rtl/bit_store.sv
// Flip-flop bit buffer for slave readout, one bit per entry.
// Assumes DEPTH is two to the AW; a push into a full store is dropped.
`timescale 1ns/100ps
module bit_store #(
  parameter int DEPTH = rds_pkg::BUF_DEPTH,
  parameter int AW = rds_pkg::BUF_AW
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic clear,
  input wire logic push,
  input wire logic push_bit,
  input wire logic pop,
  output logic head,
  output logic empty,
  output logic full,
  output logic [AW:0] fill
);

  typedef struct packed {
    logic [DEPTH-1:0] mem;
    logic [AW-1:0] wr;
    logic [AW-1:0] rd;
    logic [AW:0] fill;
  } store_t;

  store_t r;
  store_t n;
  logic do_push;
  logic do_pop;

  always_comb
  begin
    n = r;
    do_push = push && !full;
    do_pop = pop && !empty;
    if (clear)
    begin
      n.wr = '0;
      n.rd = '0;
      n.fill = '0;
    end
    else
    begin
      if (do_push)
      begin
        n.mem[r.wr] = push_bit;
        n.wr = r.wr + 1'b1;
      end
      if (do_pop)
        n.rd = r.rd + 1'b1;
      n.fill = r.fill + {{AW{1'b0}}, do_push} - {{AW{1'b0}}, do_pop};
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      r <= '0;
    else
      r <= n;
  end

  assign head = r.mem[r.rd];
  assign empty = (r.fill == '0);
  assign full = (r.fill == (AW + 1)'(DEPTH));
  assign fill = r.fill;

endmodule : bit_store

// ### bench/host_model.sv
// Host model that reads the slave readout port with its own clock.
// Assumes ready is the resolved open-drain level with a pull-up.
`timescale 1ns/100ps
module host_model (
  input wire logic enable,
  input wire logic ready,
  input wire logic data_in,
  output logic clk_out,
  output logic bit_valid,
  output logic bit_val
);
  logic tick = 1'b0;

  // 125 ns link base, phase unrelated to pclk
  initial
  begin
    #7;
    forever #62.5 tick = ~tick;
  end

  initial
  begin
    clk_out = 1'b0;
    bit_valid = 1'b0;
    bit_val = 1'b0;
    forever
    begin
      @(posedge tick);
      bit_valid = 1'b0;
      if (enable && ready)
      begin
        clk_out = 1'b1;
        repeat (7) @(posedge tick);
        bit_val = data_in;
        bit_valid = 1'b1;
        clk_out = 1'b0;
        // Ready looked at only after the update delay
        repeat (7) @(posedge tick);
      end
    end
  end
endmodule : host_model

// ### bench/rds_data_readout_port_tb.sv
// Self-checking bench for the serial readout port and its registers.
// Assumes a host model on the clock pin and a pull-up on the status pin.
`timescale 1ns/100ps
module rds_data_readout_port_tb;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic test_pin, mode_pin, reset_pin, demod_valid, demod_bit, demod_reliable;
  logic valid_data_detect, host_en, host_clk, clk_o, clk_oe, sdo, st_o, st_oe, bv, bval;
  int miscompares = 0;
  int total_checks = 0;
  // Bit, reliable, expected data, expected pull-low
  logic [3:0] rows [4] = '{4'b1011, 4'b1110, 4'b0001, 4'b0100};
  logic q [$];
  wire clk_pin = clk_oe ? clk_o : host_clk;
  wire status_level = st_oe ? st_o : 1'b1;

  rds_data_readout_port dut (.pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel),
    .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .test_pin(test_pin), .mode_pin(mode_pin), .reset_pin(reset_pin),
    .demod_valid(demod_valid), .demod_bit(demod_bit), .demod_reliable(demod_reliable),
    .valid_data_detect(valid_data_detect), .readout_clock_i(clk_pin),
    .readout_clock_o(clk_o), .readout_clock_oe(clk_oe), .serial_data_out(sdo),
    .shared_status_o(st_o), .shared_status_oe(st_oe));
  host_model host (.enable(host_en), .ready(status_level), .data_in(sdo),
    .clk_out(host_clk), .bit_valid(bv), .bit_val(bval));

  initial
  begin
    pclk = 1'b0;
    forever #4 pclk = ~pclk;
  end

  always @(posedge bv) q.push_back(bval);

  task automatic compare(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp)
    begin
      miscompares++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : compare

  task automatic test_done;
    $display("checks %0d mismatches %0d", total_checks, miscompares);
    if (miscompares == 0 && total_checks > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask : test_done

  task automatic cyc(input int n);
    repeat (n) @(posedge pclk);
  endtask : cyc

  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do
    begin
      @(posedge pclk);
      n++;
    end
    while (pready !== 1'b1 && n < 16);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (pready !== 1'b1)
    begin
      miscompares++;
      test_done;
    end
    // Idle edge, so back-to-back calls never reassign psel in one step
    @(posedge pclk);
  endtask : apb

  task automatic pulse_detect;
    valid_data_detect <= 1'b1;
    cyc(1);
    valid_data_detect <= 1'b0;
    cyc(2);
  endtask : pulse_detect

  task automatic push(input logic b, input logic r);
    demod_valid <= 1'b1;
    demod_bit <= b;
    demod_reliable <= r;
    cyc(1);
    demod_valid <= 1'b0;
    cyc(2);
  endtask : push

  initial
  begin
    int n;
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    test_pin = 1'b0;
    mode_pin = 1'b0;
    reset_pin = 1'b0;
    demod_valid = 1'b0;
    demod_bit = 1'b0;
    demod_reliable = 1'b0;
    valid_data_detect = 1'b0;
    host_en = 1'b0;
    cyc(6);
    compare(32'({clk_o, sdo, clk_oe, st_oe}), 32'h0000000c);
    presetn <= 1'b1;
    cyc(5);
    compare(32'({clk_o, sdo, clk_oe}), 32'h00000007);
    apb(1'b0, rds_pkg::ADDR_CTRL, 32'h0);
    compare(rd, 32'(rds_pkg::CTRL_RESET));
    apb(1'b1, 8'h0c, 32'h5);
    compare(32'(err), 32'h1);
    apb(1'b0, rds_pkg::ADDR_STATUS, 32'h0);
    compare(32'(rd[rds_pkg::ST_MASTER]), 32'h1);
    pulse_detect;
    for (int i = 0; i < 4; i++)
    begin
      push(rows[i][3], rows[i][2]);
      compare(32'({clk_o, sdo, st_oe}), 32'({1'b1, rows[i][1:0]}));
      cyc(100);
      // Data must still stand after the falling clock
      compare(32'({clk_o, sdo}), 32'({1'b0, rows[i][1]}));
    end
    apb(1'b0, rds_pkg::ADDR_BITS, 32'h0);
    compare(32'(rd[15:0]), 32'h4);
    mode_pin <= 1'b1;
    cyc(5);
    compare(32'(clk_oe), 32'h0);
    for (int i = 0; i < 4; i++)
      push(i != 1, 1'b1);
    compare(32'(status_level), 32'h1);
    apb(1'b0, rds_pkg::ADDR_STATUS, 32'h0);
    compare(32'(rd[14:8]), 32'h4);
    host_en <= 1'b1;
    for (n = 0; n < 4000 && q.size() < 4; n++)
      cyc(1);
    if (q.size() != 4)
    begin
      miscompares++;
      test_done;
    end
    for (int i = 0; i < 4; i++)
      compare(32'(q[i]), 32'(i != 1));
    cyc(200);
    compare(32'({st_o, st_oe}), 32'h1);
    host_en <= 1'b0;
    push(1'b1, 1'b1);
    push(1'b0, 1'b1);
    // Channel change discards the stale bits
    reset_pin <= 1'b1;
    cyc(5);
    compare(32'(st_oe), 32'h1);
    reset_pin <= 1'b0;
    cyc(5);
    push(1'b1, 1'b1);
    apb(1'b0, rds_pkg::ADDR_STATUS, 32'h0);
    compare(32'(rd[14:8]), 32'h0);
    pulse_detect;
    push(1'b0, 1'b0);
    compare(32'(status_level), 32'h1);
    host_en <= 1'b1;
    cyc(300);
    host_en <= 1'b0;
    compare(32'({q.size() == 5, q[4]}), 32'h2);
    compare(32'(status_level), 32'h0);
    // Back to master only once the buffer has run dry
    mode_pin <= 1'b0;
    cyc(5);
    compare(32'(clk_oe), 32'h1);
    // Test and mode never high together
    mode_pin <= 1'b0;
    test_pin <= 1'b1;
    cyc(5);
    compare(32'({clk_oe, st_oe}), 32'h0);
    apb(1'b0, rds_pkg::ADDR_STATUS, 32'h0);
    compare(32'(rd[rds_pkg::ST_STANDBY]), 32'h1);
    test_done;
  end
endmodule : rds_data_readout_port_tb
